// ### hdl/nvc_pkg.sv
// package: constants for the non-volatile data memory controller
package nvc_pkg;
    // memory size and address width
    localparam int NVC_DEPTH = 512;
    localparam int NVC_AW = 9;
    localparam logic [7:0] NVC_ERASED = 8'hFF;
    // io register space locations
    localparam logic [5:0] NVC_IO_CTRL = 6'h1C;
    localparam logic [5:0] NVC_IO_DATA = 6'h1D;
    localparam logic [5:0] NVC_IO_ADRL = 6'h1E;
    localparam logic [5:0] NVC_IO_ADRH = 6'h1F;
    // control register field positions
    localparam int NVC_B_READ = 0;
    localparam int NVC_B_TRIG = 1;
    localparam int NVC_B_ARM = 2;
    localparam int NVC_B_RIE = 3;
    localparam int NVC_B_MODE = 4;
    // programming modes
    localparam logic [1:0] NVC_MODE_ATOMIC = 2'h0;
    localparam logic [1:0] NVC_MODE_ERASE = 2'h1;
    localparam logic [1:0] NVC_MODE_WRITE = 2'h2;
    localparam logic [1:0] NVC_MODE_RSVD = 2'h3;
    // core clock cycle counts
    localparam logic [2:0] NVC_ARM_CYCLES = 3'h4;
    localparam logic [2:0] NVC_STALL_READ = 3'h4;
    localparam logic [2:0] NVC_STALL_PROG = 3'h2;
    // programming times, microseconds, and oscillator rate
    localparam int NVC_ATOMIC_US = 3400;
    localparam int NVC_SPLIT_US = 1800;
    localparam int NVC_OSC_MHZ = 8;
    localparam int NVC_TW = 16;
    localparam int NVC_ATOMIC_TICKS = NVC_ATOMIC_US * NVC_OSC_MHZ;
    localparam int NVC_SPLIT_TICKS = NVC_SPLIT_US * NVC_OSC_MHZ;
    localparam logic [7:0] NVC_RESET_BYTE = 8'h00;
endpackage : nvc_pkg

// ### hdl/nvc_tmr_if.sv
// interface: start request and status between controller and timer
interface nvc_tmr_if;
    logic start;
    logic [nvc_pkg::NVC_TW-1:0] ticks;
    logic busy;
    logic done;
    modport ctrl (output start, output ticks, input busy, input done);
    modport timer (input start, input ticks, output busy, output done);
endinterface : nvc_tmr_if

// ### hdl/nvc_prog_timer.sv
// module: programming timer counting calibrated oscillator edges
module nvc_prog_timer (
    input wire logic core_clk,
    input wire logic por_n,
    input wire logic clk_en,
    input wire logic osc_clk_in,
    nvc_tmr_if.timer tmr
);
    import nvc_pkg::*;
    logic sync1_r, sync2_r, sync3_r;
    logic busy_r, busy_nxt, done_r, done_nxt;
    logic [NVC_TW-1:0] cnt_r, cnt_nxt;
    logic tick;

    assign tick = sync2_r & ~sync3_r;
    assign tmr.busy = busy_r;
    assign tmr.done = done_r;

    ////////////////////////////////////////////////////////////////////////
    // [R14] oscillator timed countdown
    always_comb begin
        busy_nxt = busy_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (!busy_r && tmr.start) begin
            busy_nxt = 1'b1;
            cnt_nxt = tmr.ticks;
        end else if (busy_r && tick) begin
            if (cnt_r <= NVC_TW'(1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - NVC_TW'(1);
            end
        end
    end

    // [R16] only power-on clears a running operation
    always_ff @(posedge core_clk or negedge por_n) begin
        if (!por_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= '0;
        end else if (clk_en) begin
            sync1_r <= osc_clk_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_start_sets_busy: assert property (  // [R8]
        @(posedge core_clk iff clk_en) disable iff (!por_n)
        (!busy_r && tmr.start) |=> busy_r && cnt_r == $past(tmr.ticks))
        else $error("start did not load timer");
    chk_done_ends_busy: assert property (  // [R13]
        @(posedge core_clk iff clk_en) disable iff (!por_n)
        done_r |-> !busy_r && $past(busy_r))
        else $error("done without busy ending");
endmodule : nvc_prog_timer

// ### hdl/nvc_ctrl.sv
// module: non-volatile data memory access controller, top level
//
// Contract
// [R1] 512 byte separate data space, each byte readable and programmable.
// [R2] address, data, control registers sit in the io register space.
// [R3] a triggered read stalls the core four clock cycles.
// [R4] a triggered programming stalls the core two clock cycles.
// [R5] software loads address and data before arming and triggering.
// [R6] mode 00 trigger within four cycles of arm: erase and write.
// [R7] combined mode runs as one operation of the atomic duration.
// [R8] trigger bit reads set until the programming completes.
// [R9] no read, erase or write starts while programming is busy.
// [R10] mode 01 erases the addressed byte, shorter duration.
// [R11] mode 10 writes data without erasing first.
// [R12] software erases before write-only; otherwise content undefined.
// [R13] busy indication shows completion; software polls it.
// [R14] programming time counted on the calibrated oscillator.
// [R15] only the arm-then-trigger sequence may program.
// [R16] reset does not abort a running programming operation.
// [R17] arm clears four cycles after set; trigger without arm ignored.
// [R18] read strobe puts the addressed byte in the data register.
// [R19] mode writes ignored while busy; reset clears mode unless busy.
// [R20] ready interrupt level while enabled, global enable set, not busy.
// [R21] mode 11 trigger starts nothing and leaves busy clear.
// [R22] read strobe or address write ignored while busy.
module nvc_ctrl #(
    parameter int ATOMIC_TICKS = nvc_pkg::NVC_ATOMIC_TICKS,
    parameter int SPLIT_TICKS = nvc_pkg::NVC_SPLIT_TICKS
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic clk_en,
    input wire logic osc_clk_in,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic global_ie,
    output logic [7:0] io_rdata_r,
    output logic core_stall_r,
    output logic ready_irq_r,
    output logic nv_busy_r
);
    import nvc_pkg::*;
    nvc_tmr_if tmr ();

    logic [NVC_AW-1:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt, rdata_nxt;
    logic [2:0] arm_cnt_r, arm_cnt_nxt, stall_r, stall_nxt;
    logic rie_r, rie_nxt;
    logic [1:0] mode_r, mode_nxt, op_mode_r;
    logic [NVC_AW-1:0] op_addr_r;
    logic [7:0] op_data_r;
    logic [7:0] mem_r [NVC_DEPTH];
    logic [7:0] wr_val;
    logic busy, ctrl_wr, start, irq_nxt;
    logic [7:0] ctrl_rd;

    nvc_prog_timer u_timer (
        .core_clk(core_clk),
        .por_n(por_n),
        .clk_en(clk_en),
        .osc_clk_in(osc_clk_in),
        .tmr(tmr)
    );

    // [R9] busy spans the memory update cycle
    assign busy = tmr.busy || tmr.done;
    assign ctrl_wr = io_we && io_addr == NVC_IO_CTRL;
    // [R8] [R13] trigger bit mirrors busy
    assign ctrl_rd = {2'h0, mode_r, rie_r, arm_cnt_r != 3'h0, busy, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // cpu side register next state
    always_comb begin
        addr_nxt = addr_r;
        data_nxt = data_r;
        rie_nxt = rie_r;
        mode_nxt = mode_r;
        start = 1'b0;
        stall_nxt = (stall_r != 3'h0) ? stall_r - 3'h1 : 3'h0;
        // [R17] arm window countdown
        arm_cnt_nxt = (arm_cnt_r != 3'h0) ? arm_cnt_r - 3'h1 : 3'h0;
        // [R2] io register decode; [R22] address held while busy
        if (io_we && !busy && io_addr == NVC_IO_ADRL)
            addr_nxt[7:0] = io_wdata;
        if (io_we && !busy && io_addr == NVC_IO_ADRH)
            addr_nxt[8] = io_wdata[0];
        if (io_we && io_addr == NVC_IO_DATA)
            data_nxt = io_wdata;
        if (ctrl_wr) begin
            rie_nxt = io_wdata[NVC_B_RIE];
            // [R19] mode frozen while busy
            if (!busy)
                mode_nxt = io_wdata[NVC_B_MODE +: 2];
            if (io_wdata[NVC_B_ARM] && arm_cnt_r == 3'h0)
                arm_cnt_nxt = NVC_ARM_CYCLES;
            // [R15] trigger only inside arm window; [R21] mode 11 inert
            if (io_wdata[NVC_B_TRIG] && arm_cnt_r != 3'h0 && !busy) begin
                arm_cnt_nxt = 3'h0;
                if (mode_r != NVC_MODE_RSVD) begin
                    start = 1'b1;
                    // [R4] programming stall
                    stall_nxt = NVC_STALL_PROG;
                end
            // [R18] read into data register; [R9] blocked while busy
            end else if (io_wdata[NVC_B_READ] && !busy) begin
                data_nxt = mem_r[addr_r];
                // [R3] read stall
                stall_nxt = NVC_STALL_READ;
            end
        end
        // [R19] reset returns mode to atomic unless programming
        if (!reset_n && !busy)
            mode_nxt = NVC_MODE_ATOMIC;
        unique case (io_addr)
            NVC_IO_CTRL: rdata_nxt = ctrl_rd;
            NVC_IO_DATA: rdata_nxt = data_r;
            NVC_IO_ADRL: rdata_nxt = addr_r[7:0];
            NVC_IO_ADRH: rdata_nxt = {7'h0, addr_r[8]};
            default: rdata_nxt = 8'h00;
        endcase
        if (!io_re)
            rdata_nxt = io_rdata_r;
        // [R20] ready interrupt level
        irq_nxt = rie_r && global_ie && !busy;
    end

    // [R7] one timed operation per mode; [R10] split modes shorter
    assign tmr.start = start;
    assign tmr.ticks = (mode_r == NVC_MODE_ATOMIC) ?
        NVC_TW'(ATOMIC_TICKS) : NVC_TW'(SPLIT_TICKS);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_r <= '0;
            data_r <= NVC_RESET_BYTE;
            rie_r <= 1'b0;
            arm_cnt_r <= 3'h0;
            stall_r <= 3'h0;
            io_rdata_r <= NVC_RESET_BYTE;
            core_stall_r <= 1'b0;
            ready_irq_r <= 1'b0;
            nv_busy_r <= 1'b0;
        end else if (clk_en) begin
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            rie_r <= rie_nxt;
            arm_cnt_r <= arm_cnt_nxt;
            stall_r <= stall_nxt;
            io_rdata_r <= rdata_nxt;
            core_stall_r <= stall_nxt != 3'h0;
            ready_irq_r <= irq_nxt;
            nv_busy_r <= busy || start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [R16] operation state survives system reset
    always_ff @(posedge core_clk or negedge por_n) begin
        if (!por_n) begin
            mode_r <= NVC_MODE_ATOMIC;
            op_mode_r <= NVC_MODE_ATOMIC;
            op_addr_r <= '0;
            op_data_r <= NVC_RESET_BYTE;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
            if (start) begin
                op_mode_r <= mode_r;
                op_addr_r <= addr_r;
                op_data_r <= data_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // [R1] storage; [R11] write only can clear bits, never set them
    always_comb begin
        unique case (op_mode_r)
            NVC_MODE_ERASE: wr_val = NVC_ERASED;
            NVC_MODE_WRITE: wr_val = mem_r[op_addr_r] & op_data_r;
            // [R6] atomic erase and write
            default: wr_val = op_data_r;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (clk_en && tmr.done)
            mem_r[op_addr_r] <= wr_val;
    end

    ////////////////////////////////////////////////////////////////////////
    chk_read_stall_four: assert property (  // [R3]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        (ctrl_wr && io_wdata[NVC_B_READ] && !io_wdata[NVC_B_TRIG] && !busy)
        |=> core_stall_r[*4] ##1 !core_stall_r)
        else $error("read stall not four cycles");
    chk_prog_stall_two: assert property (  // [R4]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        start |=> core_stall_r[*2] ##1 !core_stall_r)
        else $error("program stall not two cycles");
    chk_arm_clears: assert property (  // [R17]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        (arm_cnt_r == 3'h0 ##1 arm_cnt_r == NVC_ARM_CYCLES)
        |-> ##4 arm_cnt_r == 3'h0)
        else $error("arm bit not cleared after four cycles");
    chk_trig_needs_arm: assert property (  // [R15]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        start |-> arm_cnt_r != 3'h0 && !busy && mode_r != NVC_MODE_RSVD)
        else $error("programming started without arm");
    chk_addr_hold_busy: assert property (  // [R22]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        busy |=> addr_r == $past(addr_r))
        else $error("address changed while busy");
    chk_mode_hold_busy: assert property (  // [R19]
        @(posedge core_clk iff clk_en) disable iff (!por_n)
        busy |=> mode_r == $past(mode_r))
        else $error("mode changed while busy");
    chk_rsvd_no_busy: assert property (  // [R21]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        (ctrl_wr && io_wdata[NVC_B_TRIG] && mode_r == NVC_MODE_RSVD && !busy)
        |=> !busy)
        else $error("reserved mode started an operation");
    chk_irq_level: assert property (  // [R20]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        ##1 ready_irq_r == $past(rie_r && global_ie && !busy))
        else $error("ready interrupt level wrong");
    chk_read_blocked: assert property (  // [R9]
        @(posedge core_clk iff clk_en) disable iff (!reset_n)
        (busy && !(io_we && io_addr == NVC_IO_DATA)) |=> data_r == $past(data_r))
        else $error("data changed by read while busy");
endmodule : nvc_ctrl

// ### tb/nvc_core_model.sv
// processor core model issuing io register reads and writes
module nvc_core_model (
    input wire logic core_clk,
    input wire logic core_stall_r,
    input wire logic [7:0] io_rdata_r,
    output logic io_we,
    output logic io_re,
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        io_we = 1'b0;
        io_re = 1'b0;
        io_addr = 6'h00;
        io_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // io write, stall counted
    task automatic wr(input logic [5:0] a, input logic [7:0] d,
                      output int n);
        @(negedge core_clk);
        io_we = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge core_clk);
        io_we = 1'b0;
        n = 0;
        while (core_stall_r === 1'b1 && n < 16) begin
            n++;
            @(negedge core_clk);
        end
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        io_re = 1'b1;
        io_addr = a;
        @(negedge core_clk);
        io_re = 1'b0;
        d = io_rdata_r;
    endtask
endmodule // nvc_core_model

// ### tb/test_nvc_ctrl.sv
// self-checking bench for the non-volatile memory controller
module test_nvc_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import nvc_pkg::*;
    localparam int AT = 8;
    localparam int ST = 4;
    localparam int OSC_NS = 41;
    logic core_clk, reset_n, por_n, clk_en, osc_clk_in, global_ie, rie_b;
    logic io_we, io_re, core_stall_r, ready_irq_r, nv_busy_r;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata_r, d;
    int error_cnt, checks_done, n, c;
    int cyc, t_trig;
    nvc_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .por_n(por_n),
        .clk_en(clk_en), .osc_clk_in(osc_clk_in), .io_we(io_we),
        .io_re(io_re), .io_addr(io_addr), .io_wdata(io_wdata),
        .global_ie(global_ie), .io_rdata_r(io_rdata_r),
        .core_stall_r(core_stall_r), .ready_irq_r(ready_irq_r),
        .nv_busy_r(nv_busy_r));
    nvc_core_model core (
        .core_clk(core_clk), .core_stall_r(core_stall_r),
        .io_rdata_r(io_rdata_r), .io_we(io_we), .io_re(io_re),
        .io_addr(io_addr), .io_wdata(io_wdata));
    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;
    initial osc_clk_in = 1'b0;
    always #20.5 osc_clk_in = ~osc_clk_in;
    always @(posedge core_clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // address, data, mode, arm, k idle cycles, trigger
    task automatic prog(input logic [1:0] m, input logic [8:0] a,
                        input logic [7:0] v, input int k);
        core.wr(NVC_IO_ADRH, {7'h00, a[8]}, n);
        core.wr(NVC_IO_ADRL, a[7:0], n);
        core.wr(NVC_IO_DATA, v, n);
        core.wr(NVC_IO_CTRL, {2'b00, m, rie_b, 3'b000}, n);
        core.wr(NVC_IO_CTRL, {2'b00, m, rie_b, 3'b100}, n);
        repeat (k) @(negedge core_clk);
        t_trig = cyc;
        core.wr(NVC_IO_CTRL, {2'b00, m, rie_b, 3'b010}, n);
    endtask
    // poll busy, then check the time since the trigger in core cycles
    task automatic idle(input int ticks);
        while (nv_busy_r === 1'b1 && cyc - t_trig < 400) begin
            @(negedge core_clk);
        end
        c = cyc - t_trig;
        chk({7'h00, c >= (ticks - 1) * OSC_NS / 4 &&
             c <= ticks * OSC_NS / 4 + 10}, 8'h01, "busy time");
    endtask
    task automatic rdb(input logic [8:0] a, input logic [7:0] exp);
        core.wr(NVC_IO_ADRH, {7'h00, a[8]}, n);
        core.wr(NVC_IO_ADRL, a[7:0], n);
        core.wr(NVC_IO_CTRL, {4'h0, rie_b, 3'b001}, n);
        chk(8'(n), 8'(NVC_STALL_READ), "read stall");
        core.rd(NVC_IO_DATA, d);
        chk(d, exp, "byte");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial begin
        {error_cnt, checks_done} = '0;
        {reset_n, por_n, global_ie, rie_b} = '0;
        clk_en = 1'b1;
        repeat (16) @(negedge core_clk);
        {reset_n, por_n} = 2'b11;
        core.rd(NVC_IO_CTRL, d);
        chk(d, 8'h00, "ctrl after reset");
        {rie_b, global_ie} = 2'b11;
        core.wr(NVC_IO_CTRL, 8'h08, n);
        @(negedge core_clk);
        chk({7'h00, ready_irq_r}, 8'h01, "ready irq");
        global_ie = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({7'h00, ready_irq_r}, 8'h00, "irq gated");
        global_ie = 1'b1;
        prog(NVC_MODE_ATOMIC, 9'h1A5, 8'h3C, 0);
        chk(8'(n), 8'(NVC_STALL_PROG), "prog stall");
        chk({7'h00, ready_irq_r}, 8'h00, "irq while busy");
        core.rd(NVC_IO_CTRL, d);
        chk({7'h00, d[1]}, 8'h01, "trigger reads set");
        core.wr(NVC_IO_ADRL, 8'h00, n);
        core.wr(NVC_IO_CTRL, 8'h19, n);
        idle(AT);
        core.rd(NVC_IO_CTRL, d);
        chk({6'h00, d[5:4]}, 8'h00, "mode kept");
        chk({7'h00, d[1]}, 8'h00, "trigger cleared");
        core.rd(NVC_IO_ADRL, d);
        chk(d, 8'hA5, "address kept");
        core.rd(NVC_IO_DATA, d);
        chk(d, 8'h3C, "read blocked");
        rdb(9'h1A5, 8'h3C);
        for (int k = 2; k <= 3; k++) begin
            prog(NVC_MODE_ERASE, 9'h1A5, 8'h00, k);
            chk({7'h00, nv_busy_r}, 8'(k == 2), "arm window");
            if (k == 2) idle(ST);
        end
        rdb(9'h1A5, NVC_ERASED);
        prog(NVC_MODE_WRITE, 9'h1A5, 8'h5A, 0);
        idle(ST);
        rdb(9'h1A5, 8'h5A);
        core.wr(NVC_IO_CTRL, 8'h02, n);
        chk({7'h00, nv_busy_r}, 8'h00, "no arm");
        prog(NVC_MODE_RSVD, 9'h010, 8'h77, 0);
        chk({7'h00, nv_busy_r}, 8'h00, "reserved mode");
        prog(NVC_MODE_ATOMIC, 9'h0F0, 8'hC3, 0);
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({7'h00, nv_busy_r}, 8'h01, "busy past reset");
        idle(AT);
        rie_b = 1'b0;
        rdb(9'h0F0, 8'hC3);
        finish_test();
    end
endmodule // test_nvc_ctrl
